/* File: logic/scm_top.sv */
// Switching clock manager: tuning walk, divider, spreading, external sync supervision
//
// The strobed register port and the address map were left to the implementer.
module scm_top
    import scm_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       nrst,
    input  wire logic       ce,
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    input  wire logic [3:0] nvm_osc_tune_code,
    input  wire logic       nvm_spread_enable,
    input  wire logic       nvm_spread_width_sel,
    input  wire logic       nvm_ext_sync_enable,
    input  wire logic       nvm_ext_freq_window_sel,
    input  wire logic       nvm_switch_clock_out_enable,
    input  wire logic       hf_osc_in,
    input  wire logic       ext_clock_in_pin,
    output logic      [3:0] osc_tune_code,
    output logic            spread_on,
    output logic            spread_width_sel,
    output logic            spread_mod_up,
    output logic            pll_enable,
    output logic            pll_src_ext,
    output logic            buck_clock,
    output logic            switch_clock_out_pin,
    output logic            irq_out_n
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    scm_cfg_t    cfg;
    logic [3:0]  target_idx;
    logic [3:0]  cur_idx;
    logic [7:0]  step_cnt;
    logic [1:0]  flags;
    logic [1:0]  mask;
    logic        nvm_sync_lat;
    logic        ext_q;
    logic        ext_q2;
    logic [7:0]  per_cnt;
    logic        ext_valid;
    logic        ext_selected;
    logic        hf_q;
    logic [2:0]  div_cnt;
    logic        int_clk;
    logic [10:0] mod_cnt;
    logic [3:0]  wr_idx;
    logic        tune_hold;
    logic        step_now;
    logic [7:0]  win_min;
    logic [7:0]  win_max;

    assign wr_idx    = scm_code2idx(wdata[3:0]);
    assign tune_hold = spread_on | ext_selected;
    assign step_now  = (cur_idx != target_idx) && (step_cnt == 8'h00) && !tune_hold;
    assign win_min   = cfg.window ? 8'(WIN1_MIN_CYC) : 8'(WIN0_MIN_CYC);
    assign win_max   = cfg.window ? 8'(WIN1_MAX_CYC) : 8'(WIN0_MAX_CYC);

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            cfg.spread_en  <= nvm_spread_enable;
            cfg.spread_wid <= nvm_spread_width_sel;
            cfg.sync_en    <= nvm_ext_sync_enable;
            cfg.window     <= nvm_ext_freq_window_sel;
            cfg.out_en     <= nvm_switch_clock_out_enable;
            nvm_sync_lat   <= nvm_ext_sync_enable;
            mask           <= MASK_RESET;
        end else if (ce) begin
            if (wr && addr == ADDR_CFG) begin
                cfg <= scm_cfg_t'(wdata[4:0]);
            end
            if (wr && addr == ADDR_MASK) begin
                mask <= wdata[1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Tuning walk
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            target_idx <= (scm_code2idx(nvm_osc_tune_code) == 4'hf) ? IDX_20M
                                                                   : scm_code2idx(nvm_osc_tune_code);
            cur_idx    <= (scm_code2idx(nvm_osc_tune_code) == 4'hf) ? IDX_20M
                                                                   : scm_code2idx(nvm_osc_tune_code);
            step_cnt   <= 8'h00;
        end else if (ce) begin
            if (wr && addr == ADDR_TUNE && wr_idx <= IDX_MAX) begin
                target_idx <= wr_idx;
            end
            if (step_now) begin
                cur_idx  <= (target_idx > cur_idx) ? cur_idx + 4'h1 : cur_idx - 4'h1;
                step_cnt <= 8'(STEP_CYC - 1);
            end else if (step_cnt != 8'h00) begin
                step_cnt <= step_cnt - 8'h01;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            osc_tune_code <= 4'h0;
        end else if (ce) begin
            osc_tune_code <= scm_idx2code(cur_idx);
        end
    end

    // ------------------------------------------------------------
    // External clock supervision
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            ext_q     <= 1'b0;
            ext_q2    <= 1'b0;
            per_cnt   <= 8'h00;
            ext_valid <= 1'b0;
        end else if (ce) begin
            ext_q  <= ext_clock_in_pin;
            ext_q2 <= ext_q;
            if (ext_q && !ext_q2) begin
                ext_valid <= (per_cnt >= win_min) && (per_cnt <= win_max);
                per_cnt   <= 8'h01;
            end else if (per_cnt > win_max) begin
                ext_valid <= 1'b0;
            end else begin
                per_cnt <= per_cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            ext_selected <= 1'b0;
        end else if (ce) begin
            if (!nvm_sync_lat || !cfg.sync_en || !ext_valid) begin
                ext_selected <= 1'b0;
            end else if (!flags[FLG_EXT_FAULT]) begin
                ext_selected <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Flags: hardware set wins over a write-one clear
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            flags <= 2'h0;
        end else if (ce) begin
            for (int i = 0; i < 2; i++) begin
                if (wr && addr == ADDR_FLAGS && wdata[i]) begin
                    flags[i] <= 1'b0;
                end
            end
            if (step_now && ((target_idx > cur_idx ? cur_idx + 4'h1 : cur_idx - 4'h1) == target_idx)) begin
                flags[FLG_TUNE_DONE] <= 1'b1;
            end
            if (nvm_sync_lat && cfg.sync_en && !ext_valid) begin
                flags[FLG_EXT_FAULT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            irq_out_n <= 1'b1;
        end else if (ce) begin
            irq_out_n <= ~|(flags & ~mask);
        end
    end

    // ------------------------------------------------------------
    // Divider, spreading, PLL control, clock output
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            hf_q    <= 1'b0;
            div_cnt <= 3'h0;
            int_clk <= 1'b0;
        end else if (ce) begin
            hf_q <= hf_osc_in;
            if (hf_osc_in && !hf_q) begin
                div_cnt <= div_cnt + 3'h1;
                if (div_cnt == 3'(DIV_HALF - 1) || div_cnt == 3'(2 * DIV_HALF - 1)) begin
                    int_clk <= ~int_clk;
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            mod_cnt       <= 11'h000;
            spread_mod_up <= 1'b0;
        end else if (ce) begin
            if (!spread_on) begin
                mod_cnt       <= 11'h000;
                spread_mod_up <= 1'b0;
            end else if (mod_cnt == 11'(SPREAD_HALF_CYC - 1)) begin
                mod_cnt       <= 11'h000;
                spread_mod_up <= ~spread_mod_up;
            end else begin
                mod_cnt <= mod_cnt + 11'h001;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            spread_on            <= 1'b0;
            spread_width_sel     <= 1'b0;
            pll_enable           <= 1'b0;
            pll_src_ext          <= 1'b0;
            buck_clock           <= 1'b0;
            switch_clock_out_pin <= 1'b0;
        end else if (ce) begin
            spread_on            <= cfg.spread_en && !cfg.sync_en && !ext_selected;
            spread_width_sel     <= cfg.spread_wid;
            pll_enable           <= nvm_sync_lat;
            pll_src_ext          <= ext_selected;
            buck_clock           <= ext_selected ? ext_q2 : int_clk;
            switch_clock_out_pin <= cfg.out_en && (ext_selected ? ext_q2 : int_clk);
        end
    end

    // ------------------------------------------------------------
    // Register read
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            rdata <= 8'h00;
        end else if (ce) begin
            if (rd) begin
                case (addr)
                    ADDR_TUNE:   rdata <= {4'h0, scm_idx2code(target_idx)};
                    ADDR_CFG:    rdata <= {3'h0, cfg};
                    ADDR_FLAGS:  rdata <= {6'h00, flags};
                    ADDR_MASK:   rdata <= {6'h00, mask};
                    ADDR_STATUS: rdata <= {scm_idx2code(cur_idx), 1'b0, cur_idx != target_idx,
                                           ext_selected, !ext_valid};
                    default:     rdata <= 8'h00;
                endcase
            end else begin
                rdata <= 8'h00;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [8:0] since_step;

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            since_step <= 9'h1ff;
        end else if (ce) begin
            if (step_now) begin
                since_step <= 9'h000;
            end else if (since_step != 9'h1ff) begin
                since_step <= since_step + 9'h001;
            end
        end
    end

    chk_step_spacing: assert property (@(posedge ref_clk) disable iff (!nrst)
        step_now |-> since_step >= 9'(STEP_CYC - 1))
        else $error("tuning steps closer than the step time");

    chk_step_unit: assert property (@(posedge ref_clk) disable iff (!nrst)
        $changed(cur_idx) |-> (cur_idx == $past(cur_idx) + 4'h1) || (cur_idx == $past(cur_idx) - 4'h1))
        else $error("tuning skipped a step");

    chk_tune_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
        tune_hold |=> $stable(cur_idx))
        else $error("tuning moved while spreading or synchronized");

    chk_done_flag: assert property (@(posedge ref_clk) disable iff (!nrst)
        ce && $changed(cur_idx) && cur_idx == target_idx ##0 ce [*2] |-> ##1 !irq_out_n || mask[FLG_TUNE_DONE])
        else $error("tune done did not reach the interrupt");

    chk_spread_off: assert property (@(posedge ref_clk) disable iff (!nrst)
        ce && cfg.sync_en |=> !spread_on)
        else $error("spreading active with synchronization enabled");

    chk_pll_off: assert property (@(posedge ref_clk) disable iff (!nrst)
        !nvm_sync_lat |-> !ext_selected ##1 !pll_src_ext)
        else $error("external source used without sync capability");

    chk_fallback: assert property (@(posedge ref_clk) disable iff (!nrst)
        ce && ext_selected && !ext_valid |=> !ext_selected && flags[FLG_EXT_FAULT])
        else $error("no fallback on invalid external clock");

    chk_return: assert property (@(posedge ref_clk) disable iff (!nrst)
        $rose(ext_selected) |-> $past(ext_valid) && !$past(flags[FLG_EXT_FAULT]))
        else $error("returned to external clock too early");

    chk_out_off: assert property (@(posedge ref_clk) disable iff (!nrst)
        ce && !cfg.out_en |=> !switch_clock_out_pin)
        else $error("clock output toggles while disabled");

endmodule : scm_top

/* File: logic/scm_pkg.sv */
// Constants, register map and types of the switching clock manager
//
// Operation
// - All control logic and timers run from the one low-power control clock.
// - Oscillator code tunes the 20 MHz clock within plus or minus 20 percent.
// - Multi-step code changes walk every step in order, 5.2 us apart.
// - Reaching the programmed code sets the tune-done flag and interrupt unless masked.
// - Internal source: switching clock is the oscillator divided by 8.
// - Codes 0-4 give 20-24 MHz, 9-12 give 16-19 MHz; others unused; power-up from NVM.
// - No manual tuning steps while spreading or external synchronization is active.
// - Spread enable bit turns modulation on or off; power-up value from NVM.
// - Spread width bit picks plus/minus 5 or 10 percent; default from NVM.
// - Spreading on the internal source modulates at 24 kHz.
// - External sync enabled forces spreading off regardless of spread enable.
// - NVM sync enable 0: PLL off, internal source always.
// - NVM sync enable 1: PLL always on, sourced internally or externally.
// - Window bit accepts 2000-3000 kHz when 0, 333-500 kHz when 1.
// - Absent or out-of-window external clock: fall back internal, set fault flag.
// - Fault status is 1 while external frequency invalid, 0 while valid.
// - Return to external only after fault flag cleared and frequency valid.
// - Clock output pin low when disabled, else toggles at switching frequency.
package scm_pkg;

    // ------------------------------------------------------------
    // Register map (word addresses)
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_TUNE   = 4'h0;
    localparam logic [3:0] ADDR_CFG    = 4'h1;
    localparam logic [3:0] ADDR_FLAGS  = 4'h2;
    localparam logic [3:0] ADDR_MASK   = 4'h3;
    localparam logic [3:0] ADDR_STATUS = 4'h4;

    // CFG bit positions
    localparam int CFG_SPREAD_EN  = 0;
    localparam int CFG_SPREAD_WID = 1;
    localparam int CFG_SYNC_EN    = 2;
    localparam int CFG_WINDOW     = 3;
    localparam int CFG_OUT_EN     = 4;
    // FLAGS and MASK bit positions
    localparam int FLG_TUNE_DONE  = 0;
    localparam int FLG_EXT_FAULT  = 1;
    // STATUS bit positions
    localparam int ST_FAULT       = 0;
    localparam int ST_EXT_SEL     = 1;
    localparam int ST_BUSY        = 2;
    localparam int ST_CODE_LSB    = 4;

    localparam logic [1:0] MASK_RESET = 2'h0;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS  = 25000;
    localparam int STEP_TIME_PS   = 5200000;
    localparam int STEP_CYC       = STEP_TIME_PS / CLK_PERIOD_PS;
    localparam int SPREAD_HALF_PS = 20833333;
    localparam int SPREAD_HALF_CYC = SPREAD_HALF_PS / CLK_PERIOD_PS;
    // Accepted external periods: least rounds up, longest rounds down
    localparam int WIN0_MIN_PS    = 333333;
    localparam int WIN0_MAX_PS    = 500000;
    localparam int WIN1_MIN_PS    = 2000000;
    localparam int WIN1_MAX_PS    = 3003003;
    localparam int WIN0_MIN_CYC   = (WIN0_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WIN0_MAX_CYC   = WIN0_MAX_PS / CLK_PERIOD_PS;
    localparam int WIN1_MIN_CYC   = (WIN1_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WIN1_MAX_CYC   = WIN1_MAX_PS / CLK_PERIOD_PS;
    localparam int DIV_HALF       = 4;

    // ------------------------------------------------------------
    // Tuning code decode
    // ------------------------------------------------------------
    localparam logic [3:0] IDX_MAX  = 4'h8;
    localparam logic [3:0] IDX_20M  = 4'h4;

    typedef struct packed {
        logic out_en;
        logic window;
        logic sync_en;
        logic spread_wid;
        logic spread_en;
    } scm_cfg_t;

    // Frequency order index 0..8 = 16..24 MHz; 4'hf marks an unused code
    function automatic logic [3:0] scm_code2idx(input logic [3:0] code);
        logic [3:0] idx;
        idx = 4'hf;
        if (code <= 4'h4) begin
            idx = code + 4'h4;
        end else if (code >= 4'h9 && code <= 4'hc) begin
            idx = code - 4'h9;
        end
        return idx;
    endfunction : scm_code2idx

    function automatic logic [3:0] scm_idx2code(input logic [3:0] idx);
        return (idx >= IDX_20M) ? idx - 4'h4 : idx + 4'h9;
    endfunction : scm_idx2code

endpackage : scm_pkg

/* File: test/scm_ext_src.sv */
// Far-side model: oscillator clock and external sync clock source
module scm_ext_src (
    input  wire logic       ref_clk,
    input  wire logic       ext_run,
    input  wire logic [7:0] ext_period,
    output logic            hf_osc_in,
    output logic            ext_clock_in_pin
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Clock generation
    // ------------------------------------------------------------
    logic [1:0] hf_cnt  = 2'h0;
    logic [7:0] ext_cnt = 8'h0;

    // Oscillator stand-in: period of 4 control cycles
    assign hf_osc_in = hf_cnt[1];

    always @(posedge ref_clk) begin
        hf_cnt <= hf_cnt + 2'h1;
        if (!ext_run || ext_cnt >= ext_period - 8'h1) begin
            ext_cnt <= 8'h0;
        end else begin
            ext_cnt <= ext_cnt + 8'h1;
        end
    end

    // Half high, half low; held low while the source is stopped
    assign ext_clock_in_pin = ext_run && (ext_cnt < (ext_period >> 1));
endmodule : scm_ext_src

/* File: test/tb_top.sv */
// Self-checking testbench of the switching clock manager
module tb_top import scm_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0] a;
        logic [7:0] w;
        logic [7:0] e;
        logic       sw;
    } scm_row_t;
    localparam logic [3:0] FORD [9] = '{4'h9, 4'ha, 4'hb, 4'hc, 4'h0, 4'h1, 4'h2, 4'h3, 4'h4};
    localparam scm_row_t ROWS [9] = '{
        '{ADDR_CFG, 8'h10, 8'h10, 1'b0}, '{ADDR_FLAGS, 8'h03, 8'h00, 1'b0},
        '{ADDR_MASK, 8'h03, 8'h03, 1'b0}, '{ADDR_MASK, 8'h00, 8'h00, 1'b0},
        '{ADDR_TUNE, 8'h07, 8'h09, 1'b0}, '{4'h5, 8'hff, 8'h00, 1'b0},
        '{ADDR_STATUS, 8'hff, 8'h91, 1'b0}, '{ADDR_CFG, 8'h12, 8'h12, 1'b1},
        '{ADDR_CFG, 8'h10, 8'h10, 1'b0}};

    logic       ref_clk = 1'b0;
    logic       nrst = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic       ce = 1'b1;
    logic [3:0] nvm_code = 4'h9;
    logic       nvm_sp_en = 1'b0;
    logic       nvm_sync = 1'b1;
    logic       ext_run = 1'b0;
    logic [7:0] ext_period = 8'h10;
    logic [7:0] rdata;
    logic [3:0] osc_tune_code;
    logic       hf_osc_in, ext_clock_in_pin, spread_on, spread_width_sel, spread_mod_up;
    logic       pll_enable, pll_src_ext, buck_clock, switch_clock_out_pin, irq_out_n;
    int         fail_count = 0;
    int         check_count = 0;

    always #12.5 ref_clk = ~ref_clk;

    scm_ext_src i_scm_ext_src (.ref_clk(ref_clk), .ext_run(ext_run), .ext_period(ext_period),
        .hf_osc_in(hf_osc_in), .ext_clock_in_pin(ext_clock_in_pin));

    scm_top i_scm_top (.ref_clk(ref_clk), .nrst(nrst), .ce(ce), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .nvm_osc_tune_code(nvm_code),
        .nvm_spread_enable(nvm_sp_en), .nvm_spread_width_sel(1'b1), .nvm_ext_sync_enable(nvm_sync),
        .nvm_ext_freq_window_sel(1'b0), .nvm_switch_clock_out_enable(1'b1), .hf_osc_in(hf_osc_in),
        .ext_clock_in_pin(ext_clock_in_pin), .osc_tune_code(osc_tune_code), .spread_on(spread_on),
        .spread_width_sel(spread_width_sel), .spread_mod_up(spread_mod_up), .pll_enable(pll_enable),
        .pll_src_ext(pll_src_ext), .buck_clock(buck_clock),
        .switch_clock_out_pin(switch_clock_out_pin), .irq_out_n(irq_out_n));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic final_report;
        $display("Checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report

    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge ref_clk);
        wr    <= 1'b0;
    endtask : wr_reg

    task automatic chk_rd(input string nm, input logic [3:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge ref_clk);
        rd   <= 1'b0;
        @(negedge ref_clk);
        check(nm, 16'(rdata), 16'(exp));
    endtask : chk_rd

    function automatic logic sig(input int s);
        case (s)
            0: return buck_clock;
            1: return switch_clock_out_pin;
            2: return spread_mod_up;
            3: return pll_src_ext;
            default: return irq_out_n;
        endcase
    endfunction : sig

    task automatic wait_val(input int s, input logic v, input int bound);
        int n;
        n = 0;
        @(negedge ref_clk);
        while (sig(s) !== v && n < bound) begin
            @(negedge ref_clk);
            n++;
        end
        check_count++;
        if (sig(s) !== v) begin
            fail_count++;
            $display("[FAIL] signal %0d expected %b seen %b", s, v, sig(s));
            final_report();
        end
    endtask : wait_val

    // Cycles between two successive changes of a signal
    task automatic meas(input int s, output int n);
        logic v;
        @(negedge ref_clk);
        v = sig(s);
        wait_val(s, !v, 2000);
        n = 0;
        while (sig(s) === !v && n < 2000) begin
            @(negedge ref_clk);
            n++;
        end
    endtask : meas

    task automatic tune_walk(input int fi, input int ti);
        int d;
        int k;
        int gap;
        d = (ti > fi) ? 1 : -1;
        wr_reg(ADDR_TUNE, {4'h0, FORD[ti]});
        @(negedge ref_clk);
        for (k = fi + d; k != ti + d; k += d) begin
            gap = 0;
            while (osc_tune_code === FORD[k - d] && gap < 1000) begin
                @(negedge ref_clk);
                gap++;
            end
            check("step code", 16'(osc_tune_code), 16'(FORD[k]));
            if (gap >= 1000) final_report();
            if (k != fi + d) check("step gap", 16'(gap), 16'(STEP_CYC));
        end
        repeat (2) @(negedge ref_clk);
        check("tune irq", 16'(irq_out_n), 16'h0);
        chk_rd("tune flag", ADDR_FLAGS, 8'h01);
        wr_reg(ADDR_FLAGS, 8'h01);
        chk_rd("tune flag clear", ADDR_FLAGS, 8'h00);
        check("irq released", 16'(irq_out_n), 16'h1);
    endtask : tune_walk

    initial begin
        int n;
        logic v0;
        repeat (20) @(posedge ref_clk);
        nrst <= 1'b1;
        chk_rd("tune reset", ADDR_TUNE, 8'h09);
        chk_rd("cfg reset", ADDR_CFG, 8'h16);
        chk_rd("mask reset", ADDR_MASK, {6'h0, MASK_RESET});
        check("pll on", 16'(pll_enable), 16'h1);
        foreach (ROWS[i]) begin
            wr_reg(ROWS[i].a, ROWS[i].w);
            chk_rd("row read", ROWS[i].a, ROWS[i].e);
            check("row width", 16'(spread_width_sel), 16'(ROWS[i].sw));
        end
        tune_walk(0, 6);
        wr_reg(ADDR_CFG, 8'h11);
        wait_val(2, 1'b1, 900);
        check("spread on", 16'(spread_on), 16'h1);
        wr_reg(ADDR_TUNE, 8'h04);
        repeat (300) @(negedge ref_clk);
        check("tune held", 16'(osc_tune_code), 16'h2);
        wr_reg(ADDR_TUNE, 8'h02);
        meas(2, n);
        check("spread half", 16'(n), 16'(40000 / 24 / 2));
        wr_reg(ADDR_CFG, 8'h15);
        repeat (3) @(negedge ref_clk);
        check("spread sync off", 16'(spread_on), 16'h0);
        wr_reg(ADDR_CFG, 8'h10);
        wr_reg(ADDR_FLAGS, 8'h02);
        tune_walk(6, 8);
        tune_walk(8, 4);
        meas(0, n);
        check("buck half", 16'(n), 16'(8 * 4 / 2));
        meas(1, n);
        check("out half", 16'(n), 16'(8 * 4 / 2));
        @(posedge ref_clk);
        ce <= 1'b0;
        @(negedge ref_clk);
        v0 = buck_clock;
        n = 0;
        repeat (40) begin
            @(negedge ref_clk);
            if (buck_clock !== v0) n++;
        end
        check("ce freeze", 16'(n), 16'h0);
        @(posedge ref_clk);
        ce <= 1'b1;
        wr_reg(ADDR_CFG, 8'h00);
        @(negedge ref_clk);
        n = 0;
        repeat (100) begin
            @(negedge ref_clk);
            if (switch_clock_out_pin !== 1'b0) n++;
        end
        check("out off", 16'(n), 16'h0);
        @(posedge ref_clk);
        ext_run <= 1'b1;
        wr_reg(ADDR_CFG, 8'h14);
        repeat (100) @(negedge ref_clk);
        chk_rd("ext valid", ADDR_STATUS, 8'h00);
        check("ext held", 16'(pll_src_ext), 16'h0);
        wr_reg(ADDR_FLAGS, 8'h02);
        wait_val(3, 1'b1, 10);
        chk_rd("ext sel", ADDR_STATUS, 8'h02);
        wr_reg(ADDR_CFG, 8'h1c);
        wait_val(3, 1'b0, 300);
        wait_val(4, 1'b0, 5);
        wr_reg(ADDR_FLAGS, 8'h02);
        chk_rd("fault sticky", ADDR_FLAGS, 8'h02);
        chk_rd("fault status", ADDR_STATUS, 8'h01);
        @(posedge ref_clk);
        ext_period <= 8'h64;
        repeat (400) @(negedge ref_clk);
        chk_rd("ext valid w1", ADDR_STATUS, 8'h00);
        check("still internal", 16'(pll_src_ext), 16'h0);
        wr_reg(ADDR_MASK, 8'h02);
        wait_val(4, 1'b1, 3);
        wr_reg(ADDR_MASK, 8'h00);
        wait_val(4, 1'b0, 3);
        wr_reg(ADDR_FLAGS, 8'h02);
        wait_val(3, 1'b1, 10);
        wait_val(4, 1'b1, 5);
        @(posedge ref_clk);
        ext_run <= 1'b0;
        wait_val(3, 1'b0, 300);
        chk_rd("absent flag", ADDR_FLAGS, 8'h02);
        @(posedge ref_clk);
        nvm_code  <= 4'h7;
        nvm_sync  <= 1'b0;
        nvm_sp_en <= 1'b1;
        nrst      <= 1'b0;
        ext_period <= 8'h10;
        ext_run   <= 1'b1;
        repeat (3) @(posedge ref_clk);
        nrst <= 1'b1;
        chk_rd("tune bad nvm", ADDR_TUNE, 8'h00);
        check("spread nvm", 16'(spread_on), 16'h1);
        wr_reg(ADDR_CFG, 8'h14);
        repeat (200) @(negedge ref_clk);
        check("pll off", 16'({pll_enable, pll_src_ext, spread_on}), 16'h0);
        final_report();
    end
endmodule : tb_top
